// [src/clock_distribution_pkg.sv]
// Shared constants and types for the converter clock distribution block.
package clock_distribution_pkg;

	// Register indices; the byte address of each register is four times its index.
	localparam logic [5:0] REG_INTF_CTRL   = 6'h01;
	localparam logic [5:0] REG_POWER_CTRL  = 6'h02;
	localparam logic [5:0] REG_TX_CTRL     = 6'h13;
	localparam logic [5:0] REG_PLL_CTRL    = 6'h15;
	localparam logic [5:0] REG_PIN_SRC     = 6'h16;
	localparam logic [5:0] REG_DATA_CONFIG = 6'h20;
	localparam logic [5:0] REG_STATUS      = 6'h21;

	// Interface control register fields.
	localparam int CLK_MODE_LSB     = 5;
	localparam int CLK_MODE_MSB     = 7;
	localparam int PIN_TWO_CLK_EN   = 2;
	localparam int PIN_THREE_INVERT = 1;

	// Power control register field.
	localparam int PLL_POWER_DOWN = 2;

	// Transmit control register field.
	localparam int INTERP_LSB = 0;
	localparam int INTERP_MSB = 1;

	// PLL control register fields.
	localparam int PLL_BYPASS  = 7;
	localparam int ADC_DIV     = 5;
	localparam int ALT_TIMING  = 4;
	localparam int PLL_DIV5    = 3;
	localparam int PLL_MULT_LSB = 0;
	localparam int PLL_MULT_MSB = 2;

	// Pin source register field.
	localparam int PLL_TO_PIN_TWO = 5;

	// Data configuration register fields.
	localparam int FULL_DUPLEX_BIT = 0;
	localparam int BUS_WIDE_BIT    = 1;

	// Status register fields.
	localparam int STAT_MODE_LSB = 0;
	localparam int STAT_MODE_MSB = 6;
	localparam int STAT_LOCKED   = 8;
	localparam int STAT_TIED     = 9;

	// Reset values of the writable fields.
	localparam logic [2:0] CLK_MODE_RESET = 3'h0;
	localparam logic [2:0] PLL_MULT_RESET = 3'h0;
	localparam logic [1:0] INTERP_RESET   = 2'h0;
	localparam logic       BIT_RESET      = 1'b0;

	// Clock-mode field codes.
	localparam logic [2:0] CLK_MODE_DEFAULT  = 3'h0;
	localparam logic [2:0] CLK_MODE_OPTIONAL = 3'h1;
	localparam logic [2:0] CLK_MODE_CLONE    = 3'h2;

	// Multiplier field codes and the largest shift they select.
	localparam logic [2:0] PLL_MULT_MAX_CODE = 3'h4;

	// Interpolation field codes.
	localparam logic [1:0] INTERP_1X = 2'h0;
	localparam logic [1:0] INTERP_2X = 2'h1;
	localparam logic [1:0] INTERP_4X = 2'h2;

	// Divider ratios.
	localparam logic [2:0] DIV_NONE = 3'h1;
	localparam logic [2:0] DIV_TWO  = 3'h2;
	localparam logic [2:0] DIV_FOUR = 3'h4;
	localparam logic [2:0] DIV_FIVE = 3'h5;

	typedef enum logic [6:0] {
		MODE_1  = 7'h01,
		MODE_2  = 7'h02,
		MODE_4  = 7'h04,
		MODE_5  = 7'h08,
		MODE_7  = 7'h10,
		MODE_8  = 7'h20,
		MODE_10 = 7'h40
	} mode_t;

endpackage

// [src/clock_divider.sv]
// Divides a sampled clock, given as level and rise pulse, by a run-time ratio.
`timescale 1ns/100ps
`default_nettype none
module clock_divider #(
	parameter int WIDTH = 3
) (
	input  wire logic             clock,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] divisor,
	input  wire logic             inLevel,
	input  wire logic             inRise,
	output logic                  outLevel,
	output logic                  outRise
);
	if (WIDTH < 2) begin
		$error("clock_divider needs WIDTH of at least 2");
	end

	logic [WIDTH-1:0] count_r;
	logic [WIDTH-1:0] count_nxt;
	logic             level_r;
	logic             rise_r;
	logic             bypass;

	assign bypass = (divisor <= WIDTH'(1));
	assign count_nxt = (count_r + WIDTH'(1) >= divisor) ? '0 : count_r + WIDTH'(1);

	always_ff @(posedge clock) begin
		if (srst || bypass) begin
			count_r <= '0;
			level_r <= 1'b0;
			rise_r  <= 1'b0;
		end else if (inRise) begin
			count_r <= count_nxt;
			level_r <= (count_r < (divisor >> 1));
			rise_r  <= (count_r == '0);
		end else begin
			rise_r <= 1'b0;
		end
	end

	assign outLevel = bypass ? inLevel : level_r;
	assign outRise  = bypass ? inRise : rise_r;
endmodule
`default_nettype wire

// [src/pll_model.sv]
// Cycle-level multiplier model: locks its output period to the reference period.
`timescale 1ns/100ps
`default_nettype none
module pll_model #(
	parameter int PERIOD_WIDTH = 16
) (
	input  wire logic       clock,
	input  wire logic       srst,
	input  wire logic       refRise,
	input  wire logic [2:0] multShift,
	input  wire logic       powerDown,
	output logic            outLevel,
	output logic            outRise,
	output logic            locked
);
	if (PERIOD_WIDTH < 4) begin
		$error("pll_model needs PERIOD_WIDTH of at least 4");
	end

	localparam logic [PERIOD_WIDTH-1:0] MIN_PERIOD = PERIOD_WIDTH'(2);

	logic [PERIOD_WIDTH-1:0] refCount_r;
	logic [PERIOD_WIDTH-1:0] period_r;
	logic [PERIOD_WIDTH-1:0] phase_r;
	logic [PERIOD_WIDTH-1:0] phaseNext;
	logic [PERIOD_WIDTH-1:0] scaled;
	logic [PERIOD_WIDTH-1:0] outPeriod;
	logic [1:0]              seen_r;

	assign scaled    = period_r >> multShift;
	assign outPeriod = (scaled < MIN_PERIOD) ? MIN_PERIOD : scaled;
	assign phaseNext = phase_r + PERIOD_WIDTH'(1);
	assign locked    = seen_r[1];

	// The reference period is measured from rise to rise.
	always_ff @(posedge clock) begin
		if (srst || powerDown) begin
			refCount_r <= '0;
			period_r   <= '0;
			seen_r     <= 2'h0;
		end else if (refRise) begin
			refCount_r <= PERIOD_WIDTH'(1);
			period_r   <= refCount_r;
			seen_r     <= {seen_r[1] | seen_r[0], 1'b1};
		end else if (refCount_r != '1) begin
			refCount_r <= refCount_r + PERIOD_WIDTH'(1);
		end
	end

	// Every reference rise realigns the output phase.
	always_ff @(posedge clock) begin
		if (srst || powerDown || !locked) begin
			phase_r  <= '0;
			outLevel <= 1'b0;
			outRise  <= 1'b0;
		end else if (refRise || phaseNext >= outPeriod) begin
			phase_r  <= '0;
			outLevel <= 1'b1;
			outRise  <= 1'b1;
		end else begin
			phase_r  <= phaseNext;
			outLevel <= (phaseNext < (outPeriod >> 1));
			outRise  <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [src/converter_clock_distribution.sv]
// Clock distribution, multiplier, dividers and interface pin formatter of the converter.
//
// Contract
// - Timing bit picks Rx source; normal uses reference.
// - Alternate mode: PLL drives Rx and Tx clocks.
// - PLL multiplies 1-16x, bypass and power-down bits.
// - Optional divide-by-5 follows the PLL output.
// - Normal Rx clock is Rx reference, optionally halved.
// - Alternate Rx clock is Tx reference times PLL.
// - Rx clock ignores interleaved or parallel data.
// - DAC clock is Tx reference times PLL setting.
// - Parallel Tx data clock is DAC over interpolation.
// - Interleaved Tx data clock doubles that rate; at 1x it stays at the DAC rate.
// - Mode field zero picks mode 1, 4, 7.
// - Mode field selects optional modes 2, 5, 8, 10.
// - Pin functions follow mode, duplex and bus width.
// - Half duplex: pin one is direction input.
// - Modes 2, 5, 8 tie reference inputs together.
// - Pin two clock runs at reference or DAC rate; in mode 2 the code drives receive sync there, at half the ADC clock rate.
// - Outside full duplex, enable bit drives pin two.
// - Full duplex: pin two clocks, enable bit inverts.
// - Multiplier codes 000 to 100 give 1 to 16.
// - ADC divide bit halves the converter clock.
// - Divide-by-5 bit divides PLL block output by five.
// - Source bit picks reference or PLL for pin two; the code ignores it in full duplex.
`timescale 1ns/100ps
`default_nettype none
module converter_clock_distribution #(
	parameter int PERIOD_WIDTH = 16
) (
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic [5:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input  wire logic        rxRefClockInput,
	input  wire logic        txRefClockInput,
	input  wire logic        intfPinOneIn,
	output logic             intfPinOneOut,
	output logic             intfPinOneOe,
	output logic             intfPinTwoOut,
	output logic             intfPinTwoOe,
	output logic             intfPinThreeOut,
	output logic             adcClock,
	output logic             dacClock
);
	if (PERIOD_WIDTH < 4 || PERIOD_WIDTH > 24) begin
		$error("PERIOD_WIDTH must lie between 4 and 24");
	end

	// Configuration fields.
	logic [2:0] clkMode_r;
	logic       pinTwoClkEn_r;
	logic       pinThreeInvert_r;
	logic       pllPowerDown_r;
	logic [1:0] interp_r;
	logic       pllBypass_r;
	logic       adcDiv_r;
	logic       altTiming_r;
	logic       pllDiv5_r;
	logic [2:0] pllMult_r;
	logic       pllToPinTwo_r;
	logic       fullDuplex_r;
	logic       busWide_r;

	// Bus answer state.
	logic        accessDone;
	logic [31:0] readValue;

	// Sampled reference edges.
	logic rxRefPrev_r;
	logic txRefPrev_r;
	logic effRxLevel;
	logic effRxRise;
	logic txRise;

	// Clock tree nodes as level and rise pulse, plus the lock flag, multiplier shift and divider ratios.
	logic       pllLevel;
	logic       pllRise;
	logic       pllLocked;
	logic       preDivLevel;
	logic       preDivRise;
	logic       blockLevel;
	logic       blockRise;
	logic       rxPathLevel;
	logic       rxPathRise;
	logic       rxClkLevel;
	logic       rxClkRise;
	logic       txDataLevel;
	logic       txDataRise;
	logic [2:0] multShift;
	logic [2:0] interpRatio;
	logic [2:0] txDataRatio;

	// Formatter state.
	clock_distribution_pkg::mode_t activeMode;
	logic refsTied;
	logic interleavedTx;
	logic transmit_sync_out_r;
	logic receive_sync_out_r;
	logic pinTwoSel;

	// Register writes take effect at the edge where the master sees waitrequest low.
	assign accessDone = (read || write) && !waitrequest;

	always_ff @(posedge clock) begin
		if (srst) begin
			clkMode_r        <= clock_distribution_pkg::CLK_MODE_RESET;
			pinTwoClkEn_r    <= clock_distribution_pkg::BIT_RESET;
			pinThreeInvert_r <= clock_distribution_pkg::BIT_RESET;
			pllPowerDown_r   <= clock_distribution_pkg::BIT_RESET;
			interp_r         <= clock_distribution_pkg::INTERP_RESET;
			pllBypass_r      <= clock_distribution_pkg::BIT_RESET;
			adcDiv_r         <= clock_distribution_pkg::BIT_RESET;
			altTiming_r      <= clock_distribution_pkg::BIT_RESET;
			pllDiv5_r        <= clock_distribution_pkg::BIT_RESET;
			pllMult_r        <= clock_distribution_pkg::PLL_MULT_RESET;
			pllToPinTwo_r    <= clock_distribution_pkg::BIT_RESET;
			fullDuplex_r     <= clock_distribution_pkg::BIT_RESET;
			busWide_r        <= clock_distribution_pkg::BIT_RESET;
		end else if (write && accessDone) begin
			case (address)
				clock_distribution_pkg::REG_INTF_CTRL: begin
					clkMode_r <= writedata[clock_distribution_pkg::CLK_MODE_MSB:
						clock_distribution_pkg::CLK_MODE_LSB];
					pinTwoClkEn_r    <= writedata[clock_distribution_pkg::PIN_TWO_CLK_EN];
					pinThreeInvert_r <= writedata[clock_distribution_pkg::PIN_THREE_INVERT];
				end
				clock_distribution_pkg::REG_POWER_CTRL: begin
					pllPowerDown_r <= writedata[clock_distribution_pkg::PLL_POWER_DOWN];
				end
				clock_distribution_pkg::REG_TX_CTRL: begin
					interp_r <= writedata[clock_distribution_pkg::INTERP_MSB:
						clock_distribution_pkg::INTERP_LSB];
				end
				clock_distribution_pkg::REG_PLL_CTRL: begin
					pllBypass_r <= writedata[clock_distribution_pkg::PLL_BYPASS];
					adcDiv_r    <= writedata[clock_distribution_pkg::ADC_DIV];
					altTiming_r <= writedata[clock_distribution_pkg::ALT_TIMING];
					pllDiv5_r   <= writedata[clock_distribution_pkg::PLL_DIV5];
					pllMult_r   <= writedata[clock_distribution_pkg::PLL_MULT_MSB:
						clock_distribution_pkg::PLL_MULT_LSB];
				end
				clock_distribution_pkg::REG_PIN_SRC: begin
					pllToPinTwo_r <= writedata[clock_distribution_pkg::PLL_TO_PIN_TWO];
				end
				clock_distribution_pkg::REG_DATA_CONFIG: begin
					fullDuplex_r <= writedata[clock_distribution_pkg::FULL_DUPLEX_BIT];
					busWide_r    <= writedata[clock_distribution_pkg::BUS_WIDE_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		readValue = 32'h0;
		case (address)
			clock_distribution_pkg::REG_INTF_CTRL: begin
				readValue[clock_distribution_pkg::CLK_MODE_MSB:
					clock_distribution_pkg::CLK_MODE_LSB] = clkMode_r;
				readValue[clock_distribution_pkg::PIN_TWO_CLK_EN]   = pinTwoClkEn_r;
				readValue[clock_distribution_pkg::PIN_THREE_INVERT] = pinThreeInvert_r;
			end
			clock_distribution_pkg::REG_POWER_CTRL: begin
				readValue[clock_distribution_pkg::PLL_POWER_DOWN] = pllPowerDown_r;
			end
			clock_distribution_pkg::REG_TX_CTRL: begin
				readValue[clock_distribution_pkg::INTERP_MSB:
					clock_distribution_pkg::INTERP_LSB] = interp_r;
			end
			clock_distribution_pkg::REG_PLL_CTRL: begin
				readValue[clock_distribution_pkg::PLL_BYPASS] = pllBypass_r;
				readValue[clock_distribution_pkg::ADC_DIV]    = adcDiv_r;
				readValue[clock_distribution_pkg::ALT_TIMING] = altTiming_r;
				readValue[clock_distribution_pkg::PLL_DIV5]   = pllDiv5_r;
				readValue[clock_distribution_pkg::PLL_MULT_MSB:
					clock_distribution_pkg::PLL_MULT_LSB] = pllMult_r;
			end
			clock_distribution_pkg::REG_PIN_SRC: begin
				readValue[clock_distribution_pkg::PLL_TO_PIN_TWO] = pllToPinTwo_r;
			end
			clock_distribution_pkg::REG_DATA_CONFIG: begin
				readValue[clock_distribution_pkg::FULL_DUPLEX_BIT] = fullDuplex_r;
				readValue[clock_distribution_pkg::BUS_WIDE_BIT]    = busWide_r;
			end
			clock_distribution_pkg::REG_STATUS: begin
				readValue[clock_distribution_pkg::STAT_MODE_MSB:
					clock_distribution_pkg::STAT_MODE_LSB] = activeMode;
				readValue[clock_distribution_pkg::STAT_LOCKED] = pllLocked;
				readValue[clock_distribution_pkg::STAT_TIED]   = refsTied;
			end
			default: begin
			end
		endcase
	end

	// One wait cycle per access; waitrequest rests high between accesses.
	always_ff @(posedge clock) begin
		if (srst) begin
			waitrequest <= 1'b1;
			readdata    <= 32'h0;
		end else if ((read || write) && waitrequest) begin
			waitrequest <= 1'b0;
			readdata    <= read ? readValue : 32'h0;
		end else begin
			waitrequest <= 1'b1;
		end
	end

	// Mode decode from field, duplex and bus width.
	always_comb begin
		case ({fullDuplex_r, busWide_r})
			2'b10, 2'b11: begin
				activeMode = (clkMode_r == clock_distribution_pkg::CLK_MODE_OPTIONAL) ?
					clock_distribution_pkg::MODE_2 : clock_distribution_pkg::MODE_1;
			end
			2'b01: begin
				activeMode = (clkMode_r == clock_distribution_pkg::CLK_MODE_OPTIONAL) ?
					clock_distribution_pkg::MODE_5 : clock_distribution_pkg::MODE_4;
			end
			default: begin
				if (clkMode_r == clock_distribution_pkg::CLK_MODE_OPTIONAL) begin
					activeMode = clock_distribution_pkg::MODE_8;
				end else if (clkMode_r == clock_distribution_pkg::CLK_MODE_CLONE) begin
					activeMode = clock_distribution_pkg::MODE_10;
				end else begin
					activeMode = clock_distribution_pkg::MODE_7;
				end
			end
		endcase
	end

	assign refsTied = (activeMode == clock_distribution_pkg::MODE_2) ||
		(activeMode == clock_distribution_pkg::MODE_5) ||
		(activeMode == clock_distribution_pkg::MODE_8);
	assign interleavedTx = !((activeMode == clock_distribution_pkg::MODE_4) ||
		(activeMode == clock_distribution_pkg::MODE_5));

	always_ff @(posedge clock) begin
		if (srst) begin
			rxRefPrev_r <= 1'b0;
			txRefPrev_r <= 1'b0;
		end else begin
			rxRefPrev_r <= rxRefClockInput;
			txRefPrev_r <= txRefClockInput;
		end
	end

	assign txRise     = txRefClockInput && !txRefPrev_r;
	assign effRxLevel = refsTied ? txRefClockInput : rxRefClockInput;
	assign effRxRise  = refsTied ? txRise : (rxRefClockInput && !rxRefPrev_r);

	// Codes above the largest one select the largest multiplier.
	assign multShift = (pllMult_r > clock_distribution_pkg::PLL_MULT_MAX_CODE) ?
		clock_distribution_pkg::PLL_MULT_MAX_CODE : pllMult_r;

	pll_model #(
		.PERIOD_WIDTH(PERIOD_WIDTH)
	) pllCore (
		.clock    (clock),
		.srst     (srst),
		.refRise  (txRise),
		.multShift(multShift),
		.powerDown(pllPowerDown_r),
		.outLevel (pllLevel),
		.outRise  (pllRise),
		.locked   (pllLocked)
	);

	assign preDivLevel = pllBypass_r ? txRefClockInput : pllLevel;
	assign preDivRise  = pllBypass_r ? txRise : pllRise;

	clock_divider #(
		.WIDTH(3)
	) divFive (
		.clock   (clock),
		.srst    (srst),
		.divisor (pllDiv5_r ? clock_distribution_pkg::DIV_FIVE :
			clock_distribution_pkg::DIV_NONE),
		.inLevel (preDivLevel),
		.inRise  (preDivRise),
		.outLevel(blockLevel),
		.outRise (blockRise)
	);

	assign rxPathLevel = altTiming_r ? blockLevel : effRxLevel;
	assign rxPathRise  = altTiming_r ? blockRise : effRxRise;

	clock_divider #(
		.WIDTH(3)
	) divAdc (
		.clock   (clock),
		.srst    (srst),
		.divisor (adcDiv_r ? clock_distribution_pkg::DIV_TWO :
			clock_distribution_pkg::DIV_NONE),
		.inLevel (rxPathLevel),
		.inRise  (rxPathRise),
		.outLevel(rxClkLevel),
		.outRise (rxClkRise)
	);

	always_comb begin
		case (interp_r)
			clock_distribution_pkg::INTERP_2X: interpRatio = clock_distribution_pkg::DIV_TWO;
			clock_distribution_pkg::INTERP_4X: interpRatio = clock_distribution_pkg::DIV_FOUR;
			default: interpRatio = clock_distribution_pkg::DIV_NONE;
		endcase
	end

	// A 1x ratio in an interleaved mode cannot be doubled and stays at the DAC rate.
	assign txDataRatio = interleavedTx ? (interpRatio >> 1) : interpRatio;

	clock_divider #(
		.WIDTH(3)
	) divTxData (
		.clock   (clock),
		.srst    (srst),
		.divisor (txDataRatio),
		.inLevel (blockLevel),
		.inRise  (blockRise),
		.outLevel(txDataLevel),
		.outRise (txDataRise)
	);

	// Sync outputs mark alternate words of the interleaved streams.
	always_ff @(posedge clock) begin
		if (srst) begin
			transmit_sync_out_r <= 1'b0;
			receive_sync_out_r <= 1'b0;
		end else begin
			if (txDataRise) begin
				transmit_sync_out_r <= !transmit_sync_out_r;
			end
			if (rxClkRise) begin
				receive_sync_out_r <= !receive_sync_out_r;
			end
		end
	end

	assign pinTwoSel = pllToPinTwo_r ? blockLevel : effRxLevel;

	// Output formatter.
	always_ff @(posedge clock) begin
		if (srst) begin
			intfPinOneOut   <= 1'b0;
			intfPinOneOe    <= 1'b0;
			intfPinTwoOut   <= 1'b0;
			intfPinTwoOe    <= 1'b0;
			intfPinThreeOut <= 1'b0;
			adcClock        <= 1'b0;
			dacClock        <= 1'b0;
		end else begin
			adcClock <= rxClkLevel;
			dacClock <= blockLevel;
			if (fullDuplex_r) begin
				intfPinOneOut <= transmit_sync_out_r;
				intfPinOneOe  <= 1'b1;
				intfPinTwoOe  <= 1'b1;
				if (activeMode == clock_distribution_pkg::MODE_2) begin
					intfPinTwoOut <= receive_sync_out_r ^ pinTwoClkEn_r;
				end else begin
					intfPinTwoOut <= effRxLevel ^ pinTwoClkEn_r;
				end
				intfPinThreeOut <= txDataLevel ^ pinThreeInvert_r;
			end else begin
				intfPinOneOut <= 1'b0;
				intfPinOneOe  <= 1'b0;
				intfPinTwoOe  <= pinTwoClkEn_r;
				intfPinTwoOut <= pinTwoClkEn_r && pinTwoSel;
				if (intfPinOneIn) begin
					intfPinThreeOut <= txDataLevel ^ pinThreeInvert_r;
				end else begin
					intfPinThreeOut <= rxClkLevel ^ pinThreeInvert_r;
				end
			end
		end
	end
endmodule
`default_nettype wire

// [verification/clock_distribution_asserts.sv]
// Port-level assertions for the converter clock distribution block.
`timescale 1ns/100ps
`default_nettype none
module clock_distribution_asserts (
	input wire logic        clock,
	input wire logic        srst,
	input wire logic [5:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic        intfPinOneOut,
	input wire logic        intfPinOneOe,
	input wire logic        intfPinTwoOut,
	input wire logic        intfPinTwoOe,
	input wire logic        intfPinThreeOut,
	input wire logic        adcClock,
	input wire logic        dacClock
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);

	sequence s_answer;
		!waitrequest ##1 waitrequest;
	endsequence

	a_wait_answer: assert property ((read || write) && waitrequest |=> s_answer)
		else $error("access not answered in one cycle");
	a_wait_cause: assert property (!waitrequest |-> $past(read || write))
		else $error("waitrequest low without a request");
	a_idle_high: assert property (!(read || write) && !$past(read || write) |-> waitrequest)
		else $error("waitrequest low while idle");
	a_unmapped_zero: assert property (read && !waitrequest && address == 6'h3f |-> readdata == 32'h0)
		else $error("unmapped read not zero");
	a_reset_quiet: assert property (disable iff (1'b0) srst |=> waitrequest && !dacClock
		&& !adcClock && !intfPinThreeOut && !intfPinOneOe)
		else $error("outputs active after reset");
	a_pin_one_quiet: assert property (!intfPinOneOe |-> !intfPinOneOut)
		else $error("pin one driven high while released");
	a_pin_two_quiet: assert property (!intfPinTwoOe |-> !intfPinTwoOut)
		else $error("pin two high while disabled");
	a_duplex_pair: assert property (intfPinOneOe |-> intfPinTwoOe)
		else $error("full duplex pin two not driven");
	a_pll_settle: assert property ($fell(srst) |-> !dacClock [*4])
		else $error("multiplier output before lock");
endmodule
bind converter_clock_distribution clock_distribution_asserts checker_inst (
	.clock(clock), .srst(srst), .address(address), .read(read), .write(write),
	.readdata(readdata), .waitrequest(waitrequest), .intfPinOneOut(intfPinOneOut),
	.intfPinOneOe(intfPinOneOe), .intfPinTwoOut(intfPinTwoOut), .intfPinTwoOe(intfPinTwoOe),
	.intfPinThreeOut(intfPinThreeOut), .adcClock(adcClock), .dacClock(dacClock));
`default_nettype wire

// [verification/back_end_model.sv]
// Baseband back-end model that drives the direction level on interface pin one.
`timescale 1ns/100ps
`default_nettype none
module back_end_model (
	input wire logic clock,
	input wire logic wantTx,
	input wire logic pinOneOut,
	input wire logic pinOneOe,
	output logic     pinOneWire
);
	logic dirTx_r;
	always_ff @(posedge clock) begin
		dirTx_r <= wantTx;
	end
	// The back end drives the line only while the device leaves it free.
	assign pinOneWire = pinOneOe ? pinOneOut : dirTx_r;
endmodule
`default_nettype wire

// [verification/test_converter_clock_distribution.sv]
// Self-checking testbench for the converter clock distribution block.
`timescale 1ns/100ps
`default_nettype none
module test_converter_clock_distribution;
	logic        clock = 1'b0;
	logic        srst = 1'b1;
	logic [5:0]  address = 6'h00;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata, q;
	logic        waitrequest, pinOneIn, pinOneOut, pinOneOe, pinTwoOut, pinTwoOe;
	logic        pinThreeOut, adcClock, dacClock;
	logic        rxRef = 1'b0, txRef = 1'b0, wantTx = 1'b1, counting = 1'b0;
	logic [3:0]  mon, prev = 4'h0;
	logic [15:0] modeTbl[8] = '{16'h4001, 16'h5202, 16'h6001, 16'h8004, 16'h9208,
		16'h0010, 16'h1220, 16'h2040};
	int          cnt[4], txCnt = 0, rxCnt = 0, bad_count = 0, cmp_count = 0;

	always #2.5 clock = ~clock;

	converter_clock_distribution #(.PERIOD_WIDTH(8)) DUT (.clock(clock), .srst(srst),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .rxRefClockInput(rxRef),
		.txRefClockInput(txRef), .intfPinOneIn(pinOneIn), .intfPinOneOut(pinOneOut),
		.intfPinOneOe(pinOneOe), .intfPinTwoOut(pinTwoOut), .intfPinTwoOe(pinTwoOe),
		.intfPinThreeOut(pinThreeOut), .adcClock(adcClock), .dacClock(dacClock));
	back_end_model partner (.clock(clock), .wantTx(wantTx), .pinOneOut(pinOneOut),
		.pinOneOe(pinOneOe), .pinOneWire(pinOneIn));

	// Tx reference has a period of 8 cycles, Rx reference 10 cycles.
	always @(posedge clock) begin
		txCnt <= (txCnt + 1) % 8;
		rxCnt <= (rxCnt + 1) % 10;
		txRef <= (txCnt < 4);
		rxRef <= (rxCnt < 5);
	end

	assign mon = {pinTwoOut, pinThreeOut, adcClock, dacClock};
	always @(posedge clock) begin
		prev <= mon;
		for (int i = 0; i < 4; i++) if (counting && mon[i] && !prev[i]) cnt[i]++;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("compares %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic acc(input logic [5:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		address <= a;
		write <= w;
		read <= !w;
		writedata <= d;
		do begin
			@(posedge clock);
			n++;
		end while (waitrequest !== 1'b0 && n < 40);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (n >= 40) begin
			bad_count++;
			print_verdict();
		end
	endtask

	task automatic rd(input logic [5:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hffffffff);
		acc(a, 1'b0, 32'h0);
		check(q & m, e);
	endtask

	// Sets up the clock tree, then counts rises of dac, adc, pin three, pin two.
	task automatic cfg(input logic [7:0] r01, r13, r15, r16, r20, input int d, a, t, w);
		int e[4];
		e = '{d, a, t, w};
		acc(6'h01, 1'b1, {24'h0, r01});
		acc(6'h13, 1'b1, {24'h0, r13});
		acc(6'h15, 1'b1, {24'h0, r15});
		acc(6'h16, 1'b1, {24'h0, r16});
		acc(6'h20, 1'b1, {24'h0, r20});
		repeat (60) @(posedge clock);
		cnt = '{0, 0, 0, 0};
		counting <= 1'b1;
		repeat (400) @(posedge clock);
		counting <= 1'b0;
		for (int i = 0; i < 4; i++) check(32'(cnt[i] >= e[i] - 2 && cnt[i] <= e[i] + 2), 32'h1);
	endtask

	initial begin
		repeat (20) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		rd(6'h01, 32'h0);
		rd(6'h02, 32'h0);
		rd(6'h13, 32'h0);
		rd(6'h15, 32'h0);
		rd(6'h16, 32'h0);
		rd(6'h20, 32'h0);
		rd(6'h3f, 32'h0);
		acc(6'h21, 1'b1, 32'hffffffff);
		rd(6'h21, 32'h10, 32'h27f);
		acc(6'h15, 1'b1, 32'hffffffff);
		rd(6'h15, 32'hbf);
		$display("test registers done");
		acc(6'h13, 1'b1, 32'h1);
		foreach (modeTbl[i]) begin
			acc(6'h20, 1'b1, {30'h0, modeTbl[i][15:14]});
			acc(6'h01, 1'b1, {24'h0, 1'b0, modeTbl[i][13:12], 5'h0});
			rd(6'h21, {22'h0, modeTbl[i][9:0]}, 32'h27f);
			check(32'(pinOneOe), 32'(modeTbl[i][14]));
		end
		$display("test modes done");
		// Interleaved modes get 2x or 4x interpolation here, parallel modes 1x or 4x.
		cfg(8'h0, 8'h1, 8'h80, 8'h0, 8'h0, 50, 40, 50, 0);
		rd(6'h21, 32'h100, 32'h100);
		cfg(8'h0, 8'h1, 8'ha0, 8'h0, 8'h0, 50, 20, 50, 0);
		cfg(8'h0, 8'h1, 8'h88, 8'h0, 8'h0, 10, 40, 10, 0);
		cfg(8'h0, 8'h1, 8'h01, 8'h0, 8'h0, 100, 40, 100, 0);
		cfg(8'h0, 8'h1, 8'h02, 8'h0, 8'h0, 200, 40, 200, 0);
		cfg(8'h0, 8'h1, 8'h90, 8'h0, 8'h0, 50, 50, 50, 0);
		cfg(8'h0, 8'h1, 8'hb0, 8'h0, 8'h0, 50, 25, 50, 0);
		cfg(8'h0, 8'h0, 8'h80, 8'h0, 8'h2, 50, 40, 50, 0);
		check(32'(pinThreeOut ^ dacClock), 32'h0);
		cfg(8'h2, 8'h0, 8'h80, 8'h0, 8'h2, 50, 40, 50, 0);
		check(32'(pinThreeOut ^ dacClock), 32'h1);
		cfg(8'h0, 8'h2, 8'h80, 8'h0, 8'h2, 50, 40, 12, 0);
		cfg(8'h4, 8'h2, 8'h80, 8'h0, 8'h2, 50, 40, 12, 40);
		cfg(8'h4, 8'h2, 8'h80, 8'h20, 8'h2, 50, 40, 12, 50);
		cfg(8'h0, 8'h2, 8'h80, 8'h0, 8'h1, 50, 40, 25, 40);
		check(32'(pinTwoOut ^ adcClock), 32'h0);
		cfg(8'h4, 8'h2, 8'h80, 8'h0, 8'h1, 50, 40, 25, 40);
		check(32'(pinTwoOut ^ adcClock), 32'h1);
		cfg(8'h20, 8'h2, 8'h80, 8'h0, 8'h1, 50, 50, 25, 25);
		wantTx <= 1'b0;
		cfg(8'h0, 8'h1, 8'h80, 8'h0, 8'h0, 50, 40, 40, 0);
		wantTx <= 1'b1;
		acc(6'h02, 1'b1, 32'h4);
		cfg(8'h0, 8'h1, 8'h01, 8'h0, 8'h0, 0, 40, 0, 0);
		rd(6'h21, 32'h0, 32'h100);
		acc(6'h02, 1'b1, 32'h0);
		$display("test clock tree done");
		print_verdict();
	end
endmodule
`default_nettype wire
